//--- bank_regs.v
// One bank's timing and configuration register set.
// Assumes the parent decodes the bank and field and writes full words.
`timescale 1ns/10ps
`include "static_bank_map.vh"

module bank_regs #(
	parameter [7:0] CONFIG_RESET = `RST_CONFIG0
) (
	input  wire        mclk,                // System clock
	input  wire        reset,               // Synchronous reset, active high
	input  wire        wr_en,               // Write strobe for this bank
	input  wire [2:0]  wr_field,            // Field index within the bank
	input  wire [31:0] wr_data,             // Write data
	output reg  [4:0]  read_wait_count_reg, // First read wait states
	output reg  [4:0]  write_wait_count_reg,// Write or burst wait states
	output reg  [3:0]  oe_delay_count_reg,  // Select to output enable
	output reg  [3:0]  we_delay_count_reg,  // Select to write enable
	output reg  [7:0]  config_reg,          // Bank configuration
	output reg  [2:0]  wait_ctl_reg         // Delay enable, wait enable and wait polarity
);

	////////////////////////////////////////////////////////////////////////
	// Register writes; unused upper bits are simply not stored
	always @(posedge mclk) begin
		if (reset) begin
			read_wait_count_reg  <= `RST_READ_WAIT;
			write_wait_count_reg <= `RST_WRITE_WAIT;
			oe_delay_count_reg   <= `RST_OE_DELAY;
			we_delay_count_reg   <= `RST_WE_DELAY;
			config_reg           <= CONFIG_RESET;
			wait_ctl_reg         <= `RST_WAITCTL;
		end else if (wr_en) begin
			case (wr_field)
				`FLD_READ_WAIT:  read_wait_count_reg  <= wr_data[4:0];
				`FLD_WRITE_WAIT: write_wait_count_reg <= wr_data[4:0];
				`FLD_OE_DELAY:   oe_delay_count_reg   <= wr_data[3:0];
				`FLD_WE_DELAY:   we_delay_count_reg   <= wr_data[3:0];
				// Reserved bits 2 to 1 are held at zero
				`FLD_CONFIG:     config_reg <= wr_data[7:0] & `CFG_WRITE_MASK;
				`FLD_WAITCTL:    wait_ctl_reg         <= wr_data[2:0];
				default: begin
				end
			endcase
		end
	end

endmodule

//--- half_cycle_strobe.v
// Falling-edge retiming stage for the write strobe.
// Assumes the window input is produced by rising-edge logic of mclk.
`timescale 1ns/10ps
`include "static_bank_map.vh"

module half_cycle_strobe (
	input  wire mclk,       // System clock
	input  wire reset,      // Synchronous reset, active high
	input  wire window,     // Strobe window from the rising-edge logic
	output reg  strobe_reg  // Window delayed by half a clock
);

	////////////////////////////////////////////////////////////////////////
	// Sampling on the falling edge moves both edges of the window half a
	// clock later, so the strobe opens and closes mid-cycle.
	always @(negedge mclk) begin
		if (reset) begin
			strobe_reg <= 1'b0;
		end else begin
			strobe_reg <= window;
		end
	end

endmodule

//--- mem_partner.sv
// Behavioural external memory: data is a pattern of the address.
// Assumes the bench tells it the idle level of the selects.
`timescale 1ns/10ps
module mem_partner (
	input  wire        mclk,
	input  wire [3:0]  mem_cs,
	input  wire [3:0]  cs_idle,
	input  wire        mem_oe_n,
	input  wire        mem_we_n,
	input  wire [23:0] mem_addr,
	input  wire [31:0] mem_dout,
	output wire [31:0] mem_din,
	output wire        mem_wait,
	output time        oe_dt,
	output time        we_dt,
	output time        rel_dt,
	output reg  [31:0] wr_word
);
	wire [7:0]  pat = mem_addr[7:0] ^ 8'h5a; // Same byte on every lane
	reg  [31:0] last = 32'h0000_0000;        // Last value driven
	time        t_cs;                        // Select activation time
	time        t_we;                        // Write enable release time
	assign mem_wait = 1'b0;
	// Released bus shows the inverse, so a stale sample cannot match
	assign mem_din = !mem_oe_n ? {4{pat}} : ~last;
	always @(posedge mclk) if (!mem_oe_n) last <= {4{pat}};
	// Edge-to-edge timing of the strobes against the select
	always @(mem_cs) if (mem_cs != cs_idle) t_cs = $time; else rel_dt = $time - t_we;
	always @(negedge mem_oe_n) oe_dt = $time - t_cs;
	always @(negedge mem_we_n) we_dt = $time - t_cs;
	always @(posedge mem_we_n) begin
		t_we = $time;
		wr_word = mem_dout;
	end
endmodule

//--- static_bank_map.vh
// Constants for the static memory bank timing block: register offsets,
// field positions, reset values and timing floors.
// Assumes inclusion by bare name from the design files of this block.
`ifndef STATIC_BANK_MAP_VH
`define STATIC_BANK_MAP_VH

// Register offsets (bytes) and per-bank field indices
`define BANK_STRIDE      8'h1c
`define WAITCTL_BASE     8'h70
`define FLD_IDLE         3'h0
`define FLD_READ_WAIT    3'h1
`define FLD_WRITE_WAIT   3'h2
`define FLD_OE_DELAY     3'h3
`define FLD_WE_DELAY     3'h4
`define FLD_CONFIG       3'h5
`define FLD_STATUS       3'h6
`define FLD_WAITCTL      3'h7

// Reset values
`define RST_READ_WAIT    5'h1f
`define RST_WRITE_WAIT   5'h1f
`define RST_OE_DELAY     4'h0
`define RST_WE_DELAY     4'h1
`define RST_CONFIG0      8'h80
`define RST_CONFIG1      8'h00
`define RST_CONFIG2      8'h40
`define RST_CONFIG3      8'h00
`define RST_WAITCTL      3'h0

// Configuration field positions and writable mask
`define CFG_WIDTH_HI     7
`define CFG_WIDTH_LO     6
`define CFG_BURST        5
`define CFG_WPROT        4
`define CFG_SELECT_POLARITY        3
`define CFG_RBLE         0
`define CFG_WRITE_MASK   8'hf9
`define WCTL_DELAY_EN    0
`define WCTL_WAIT_EN     1
`define WCTL_WAIT_POL    2

// Bus width codes
`define WIDTH_8          2'h0
`define WIDTH_16         2'h1
`define WIDTH_32         2'h2

// Shortest access lengths in clocks
`define MIN_READ_CYCLES  5'h01
`define MIN_WRITE_CYCLES 5'h02

`endif

//--- static_bank_timing.v
// Static memory bank timing block: APB register slave, per-bank timing
// registers and the external access sequencer with width splitting.
// Assumes one clock, synchronous requests and synchronous memory inputs.
//
// Contract
// - Write wait field, 5 bits, resets 1Fh
// - Burst ROM uses write waits for bursts
// - Burst flash bursts handled like burst ROM
// - Output-enable delay field, 4 bits, resets 0
// - Output enable drops with chip select
// - Write-enable delay field, 4 bits, resets 1
// - Zero delay: WE half clock after select
// - WE drops half clock before select
// - Byte lanes follow write-enable timing exactly
// - Wide transfers split into narrower external ones
// - Config upper bits read zero
// - Assertion delays apply only when enabled
// - Wait input gated and polarity selectable
// - Width code 00/01/10, per-bank reset
// - Select polarity bit, active low reset
// - Bursts to four, split at quads
//
// The register offsets and register access over APB were left to the implementer.
`timescale 1ns/10ps
`include "static_bank_map.vh"

module static_bank_timing #(
	parameter ADDR_W = 24                 // External address width
) (
	input  wire              mclk,        // System clock, 125 MHz
	input  wire              reset,       // Synchronous reset, active high
	input  wire              psel,        // APB select
	input  wire              penable,     // APB enable
	input  wire              pwrite,      // APB direction
	input  wire [7:0]        paddr,       // APB byte address
	input  wire [31:0]       pwdata,      // APB write data
	output wire              pready,      // APB ready
	output reg  [31:0]       prdata,      // APB read data
	output wire              pslverr,     // APB error on unmapped address
	input  wire              req_valid,   // Internal transfer request
	output wire              req_ready,   // Request taken when both high
	input  wire              req_write,   // Write when high
	input  wire [1:0]        req_bank,    // Target bank
	input  wire [ADDR_W-1:0] req_addr,    // Byte address in bank
	input  wire [1:0]        req_size,    // 0 byte, 1 half, 2 word
	input  wire              req_seq,     // Sequential to previous read
	input  wire [31:0]       req_wdata,   // Write data, little endian
	output reg               rsp_valid,   // Transfer complete pulse
	output reg  [31:0]       rsp_rdata,   // Read data
	output reg               rsp_error,   // Write to protected bank
	output wire [3:0]        mem_cs,      // Chip selects, bank polarity
	output wire              mem_oe_n,    // Output enable, active low
	output wire              mem_we_n,    // Write enable, active low
	output wire [3:0]        mem_blsel_n, // Byte lane selects, active low
	output reg  [ADDR_W-1:0] mem_addr,    // External address
	output reg  [31:0]       mem_dout,    // External write data
	output wire              mem_dout_en, // High while data pins driven
	input  wire [31:0]       mem_din,     // External read data
	input  wire              mem_wait     // External wait input
);

	////////////////////////////////////////////////////////////////////////
	// Sequencer states
	localparam [1:0] ST_IDLE   = 2'h0;  // No access
	localparam [1:0] ST_ACCESS = 2'h1;  // Chip select active
	localparam [1:0] ST_GAP    = 2'h2;  // Select released between beats

	////////////////////////////////////////////////////////////////////////
	// Helper functions

	// Decode an APB address into {valid, bank, field}
	function [5:0] decode_addr;
		input [7:0] a;
		reg   [7:0] base;
		reg   [7:0] rel;
		integer     i;
		begin
			decode_addr = 6'h00;
			base = 8'h00;
			for (i = 0; i < 4; i = i + 1) begin
				rel = a - base;
				if (a >= base && rel < `BANK_STRIDE && a[1:0] == 2'h0) begin
					decode_addr = {1'b1, i[1:0], rel[4:2]};
				end
				base = base + `BANK_STRIDE;
			end
			rel = a - `WAITCTL_BASE;
			if (a >= `WAITCTL_BASE && rel < 8'h10 && a[1:0] == 2'h0) begin
				decode_addr = {1'b1, a[3:2], `FLD_WAITCTL};
			end
		end
	endfunction

	// Reserved width code is served as a 32-bit bus
	function [1:0] width_of;
		input [7:0] cfg;
		begin
			if (cfg[`CFG_WIDTH_HI:`CFG_WIDTH_LO] == 2'h3) begin
				width_of = `WIDTH_32;
			end else begin
				width_of = cfg[`CFG_WIDTH_HI:`CFG_WIDTH_LO];
			end
		end
	endfunction

	// Bit position of a beat's data within the internal word
	function [5:0] beat_shift;
		input [1:0] beat;
		input [1:0] w;
		begin
			beat_shift = {1'b0, beat, 3'h0} << w;
		end
	endfunction

	// Lanes used by one beat, from size, bus width and byte offset
	function [3:0] lane_mask;
		input [1:0] size;
		input [1:0] w;
		input [1:0] off;
		reg   [1:0] s;
		begin
			s = (size < w) ? size : w;
			case (s)
				2'h0:    lane_mask = 4'h1 << off;
				2'h1:    lane_mask = 4'h3 << off;
				default: lane_mask = 4'hf;
			endcase
		end
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Per-bank register copies
	wire [4:0] rd_wait [0:3];   // Read wait states per bank
	wire [4:0] wr_wait [0:3];   // Write or burst wait states per bank
	wire [3:0] oe_dly  [0:3];   // Output-enable delay per bank
	wire [3:0] we_dly  [0:3];   // Write-enable delay per bank
	wire [7:0] cfg     [0:3];   // Configuration per bank
	wire [2:0] wctl    [0:3];   // Delay and wait-input control per bank

	wire [5:0] dec       = decode_addr(paddr);   // Decoded APB address
	wire       dec_ok    = dec[5];               // Address is mapped
	wire [1:0] dec_bank  = dec[4:3];             // Addressed bank
	wire [2:0] dec_field = dec[2:0];             // Addressed field
	wire       apb_setup = psel & ~penable;      // APB setup phase
	wire       apb_acc   = psel & penable;       // APB access phase
	wire       apb_wr    = apb_acc & pwrite & dec_ok;

	genvar g;
	generate
		for (g = 0; g < 4; g = g + 1) begin : bank
			// Each bank owns its registers; the access picks by bank
			bank_regs #(
				.CONFIG_RESET(g == 0 ? `RST_CONFIG0 : g == 1 ? `RST_CONFIG1 :
					g == 2 ? `RST_CONFIG2 : `RST_CONFIG3)
			) u_regs (
				.mclk                (mclk),
				.reset               (reset),
				.wr_en               (apb_wr && dec_bank == g),
				.wr_field            (dec_field),
				.wr_data             (pwdata),
				.read_wait_count_reg (rd_wait[g]),
				.write_wait_count_reg(wr_wait[g]),
				.oe_delay_count_reg  (oe_dly[g]),
				.we_delay_count_reg  (we_dly[g]),
				.config_reg          (cfg[g]),
				.wait_ctl_reg        (wctl[g])
			);
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////
	// APB slave: zero wait states, read data captured in the setup phase
	assign pready  = 1'b1;
	assign pslverr = apb_acc & ~dec_ok;

	// Read mux; idle and status words are not kept here and read zero
	reg [31:0] read_word;
	always @* begin
		read_word = 32'h0000_0000;
		case (dec_field)
			`FLD_READ_WAIT:  read_word[4:0] = rd_wait[dec_bank];
			`FLD_WRITE_WAIT: read_word[4:0] = wr_wait[dec_bank];
			`FLD_OE_DELAY:   read_word[3:0] = oe_dly[dec_bank];
			`FLD_WE_DELAY:   read_word[3:0] = we_dly[dec_bank];
			`FLD_CONFIG:     read_word[7:0] = cfg[dec_bank];
			`FLD_WAITCTL:    read_word[2:0] = wctl[dec_bank];
			default:         read_word = 32'h0000_0000;
		endcase
	end

	// Register the read word so prdata comes from a flip-flop
	always @(posedge mclk) begin
		if (reset) begin
			prdata <= 32'h0000_0000;
		end else if (apb_setup) begin
			prdata <= dec_ok ? read_word : 32'h0000_0000;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Sequencer state
	reg  [1:0]        state_reg;     // Sequencer state
	reg  [1:0]        bank_reg;      // Bank of the transfer
	reg               write_reg;     // Transfer direction
	reg  [1:0]        size_reg;      // Transfer size code
	reg  [31:0]       wdata_reg;     // Whole write word
	reg  [1:0]        beat_reg;      // Current beat number
	reg  [1:0]        last_beat_reg; // Number of the final beat
	reg  [4:0]        elapsed_reg;   // Clocks since select asserted
	reg  [4:0]        len_reg;       // Length of this beat in clocks
	reg  [3:0]        lanes_reg;     // Lanes of this beat
	reg  [31:0]       acc_reg;       // Read data assembled so far

	// Request fields from the port when idle, else from the transfer
	wire        idle     = (state_reg == ST_IDLE);
	wire [1:0]  sel_bank = idle ? req_bank : bank_reg;
	wire [7:0]  cur_cfg  = cfg[sel_bank];
	wire [2:0]  cur_wctl = wctl[sel_bank];
	wire [1:0]  cur_w    = width_of(cur_cfg);
	wire        cur_wr   = idle ? req_write : write_reg;
	wire [1:0]  cur_size = idle ? req_size : size_reg;
	wire [ADDR_W-1:0] cur_addr = idle ? req_addr : mem_addr;
	wire [1:0]  next_beat = idle ? 2'h0 : beat_reg + 2'h1;
	wire [1:0]  cur_off  = cur_addr[1:0] & ~(2'h3 << cur_w);
	wire [ADDR_W-1:0] bus_bytes = {{(ADDR_W-3){1'b0}}, 3'h1 << cur_w};

	////////////////////////////////////////////////////////////////////////
	// Beat length. A read that continues a burst inside a quad uses the
	// second wait count; the quad boundary forces the first count again.
	// Split beats after the first count as sequential.
	wire [ADDR_W-1:0] loc_index = cur_addr >> cur_w;
	wire        in_quad  = (loc_index[1:0] != 2'h0);
	wire        seq_rd   = (idle ? req_seq : 1'b1) & in_quad;
	wire        burst_rd = ~cur_wr & cur_cfg[`CFG_BURST] & seq_rd;
	reg  [4:0]  beat_len;
	always @* begin
		if (cur_wr) begin
			// Writes need two clocks so the strobe fits inside select
			beat_len = (wr_wait[sel_bank] < `MIN_WRITE_CYCLES) ?
				`MIN_WRITE_CYCLES : wr_wait[sel_bank];
		end else if (burst_rd) begin
			beat_len = (wr_wait[sel_bank] < `MIN_READ_CYCLES) ?
				`MIN_READ_CYCLES : wr_wait[sel_bank];
		end else begin
			beat_len = (rd_wait[sel_bank] < `MIN_READ_CYCLES) ?
				`MIN_READ_CYCLES : rd_wait[sel_bank];
		end
	end

	// Number of the last beat when the transfer is wider than the bus
	wire [1:0]  split_last = (cur_size > cur_w) ?
		((2'h1 << (cur_size - cur_w)) - 2'h1) : 2'h0;

	////////////////////////////////////////////////////////////////////////
	// Access timing within a beat
	wire        in_access = (state_reg == ST_ACCESS);
	wire        dly_en    = cur_wctl[`WCTL_DELAY_EN];
	wire        last_clk  = (elapsed_reg == len_reg - 5'h01);
	// Wait input only counts when enabled, at the chosen level
	wire        stalled   = cur_wctl[`WCTL_WAIT_EN] &
		(mem_wait == cur_wctl[`WCTL_WAIT_POL]);
	wire        finishing = in_access & last_clk & ~stalled;
	wire        oe_due    = ~dly_en | (elapsed_reg >= {1'b0, oe_dly[bank_reg]});
	wire        we_due    = ~dly_en | (elapsed_reg >= {1'b0, we_dly[bank_reg]});
	// Window closes in the final clock so the strobe ends mid-cycle
	wire        we_window = in_access & write_reg & we_due & ~finishing;
	wire        we_strobe;                                             // Retimed strobe
	wire        prot_hit  = idle & req_valid & req_write & cur_cfg[`CFG_WPROT];

	// Falling-edge stage: strobe rises half a clock after the window
	half_cycle_strobe u_we (
		.mclk      (mclk),
		.reset     (reset),
		.window    (we_window),
		.strobe_reg(we_strobe)
	);

	// Read piece of this beat, aligned into the internal word
	wire [31:0] bus_mask  = (cur_w == `WIDTH_8) ? 32'h0000_00ff :
		(cur_w == `WIDTH_16) ? 32'h0000_ffff : 32'hffff_ffff;
	wire [31:0] rd_piece  = ((mem_din >> {cur_off, 3'h0}) & bus_mask) <<
		beat_shift(beat_reg, cur_w);
	wire [31:0] acc_next  = acc_reg | rd_piece;

	////////////////////////////////////////////////////////////////////////
	// Sequencer: start, run, and split wide transfers into beats
	always @(posedge mclk) begin
		if (reset) begin
			state_reg     <= ST_IDLE;
			bank_reg      <= 2'h0;
			write_reg     <= 1'b0;
			size_reg      <= 2'h0;
			wdata_reg     <= 32'h0000_0000;
			beat_reg      <= 2'h0;
			last_beat_reg <= 2'h0;
			elapsed_reg   <= 5'h00;
			len_reg       <= 5'h01;
			lanes_reg     <= 4'h0;
			acc_reg       <= 32'h0000_0000;
			mem_addr      <= {ADDR_W{1'b0}};
			mem_dout      <= 32'h0000_0000;
			rsp_valid     <= 1'b0;
			rsp_rdata     <= 32'h0000_0000;
			rsp_error     <= 1'b0;
		end else begin
			rsp_valid <= 1'b0;
			rsp_error <= 1'b0;
			case (state_reg)
				ST_IDLE: begin
					if (prot_hit) begin
						// Protected bank: answer at once, pins stay idle
						rsp_valid <= 1'b1;
						rsp_error <= 1'b1;
					end else if (req_valid) begin
						state_reg     <= ST_ACCESS;
						bank_reg      <= req_bank;
						write_reg     <= req_write;
						size_reg      <= req_size;
						wdata_reg     <= req_wdata;
						beat_reg      <= 2'h0;
						last_beat_reg <= split_last;
						elapsed_reg   <= 5'h00;
						len_reg       <= beat_len;
						lanes_reg     <= lane_mask(req_size, cur_w, cur_off);
						acc_reg       <= 32'h0000_0000;
						mem_addr      <= req_addr;
						mem_dout      <= req_wdata << {cur_off, 3'h0};
					end
				end
				ST_ACCESS: begin
					if (!last_clk) begin
						elapsed_reg <= elapsed_reg + 5'h01;
					end
					if (finishing) begin
						acc_reg <= acc_next;
						if (beat_reg == last_beat_reg) begin
							state_reg <= ST_IDLE;
							rsp_valid <= 1'b1;
							rsp_rdata <= write_reg ? 32'h0000_0000 : acc_next;
						end else begin
							// Select drops for one clock between beats
							state_reg <= ST_GAP;
							mem_addr  <= mem_addr + bus_bytes;
						end
					end
				end
				ST_GAP: begin
					// Next narrower beat of the same transfer
					state_reg   <= ST_ACCESS;
					beat_reg    <= next_beat;
					elapsed_reg <= 5'h00;
					len_reg     <= beat_len;
					lanes_reg   <= lane_mask(size_reg, cur_w, 2'h0);
					mem_dout    <= wdata_reg >> beat_shift(next_beat, cur_w);
				end
				default: begin
					state_reg <= ST_IDLE;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Pin outputs. Select and output enable come from the same state
	// term, so both are released on the same edge.
	assign req_ready = idle;

	genvar c;
	generate
		for (c = 0; c < 4; c = c + 1) begin : sel
			// Polarity bit set gives an active-high select
			assign mem_cs[c] = cfg[c][`CFG_SELECT_POLARITY] ?
				(in_access && bank_reg == c) : ~(in_access && bank_reg == c);
		end
	endgenerate

	assign mem_oe_n    = ~(in_access & ~write_reg & oe_due);
	assign mem_we_n    = ~we_strobe;
	assign mem_dout_en = in_access & write_reg;

	// Byte lanes: write lanes ride on the write strobe itself; reads hold
	// them low only when the read-lane option is set.
	assign mem_blsel_n = ~((lanes_reg & {4{we_strobe & write_reg}}) |
		{4{in_access & ~write_reg & cfg[bank_reg][`CFG_RBLE]}});

endmodule

//--- static_bank_timing_properties.sv
// Checker for the static bank timing block, bound to its top module.
// Assumes one clock, mclk, and the synchronous active-high reset.
`timescale 1ns/10ps
module static_bank_timing_checker (
	input wire       mclk,
	input wire       reset,
	input wire       psel,
	input wire       penable,
	input wire       pready,
	input wire       pslverr,
	input wire       req_valid,
	input wire       req_ready,
	input wire       rsp_valid,
	input wire       rsp_error,
	input wire [3:0] mem_cs,
	input wire       mem_oe_n,
	input wire       mem_we_n,
	input wire [3:0] mem_blsel_n,
	input wire       mem_dout_en
);
	// Single domain, so one clocking and one disable serve all
	default clocking cb @(posedge mclk); endclocking
	default disable iff (reset);
	chk_oe_with_cs: assert property ($rose(mem_oe_n) |-> $changed(mem_cs))
		else $error("output enable released apart from select");
	chk_we_before_cs: assert property ($changed(mem_cs) |-> $past(mem_we_n))
		else $error("write enable still low as select moved");
	chk_lane_we: assert property (mem_dout_en |-> ((mem_blsel_n != 4'hf) == !mem_we_n))
		else $error("byte lanes differ from write enable");
	chk_we_in_write: assert property (!mem_we_n |-> mem_dout_en)
		else $error("write enable outside a write");
	chk_oe_not_write: assert property (!mem_oe_n |-> !mem_dout_en)
		else $error("output enable during a write");
	chk_idle_quiet: assert property (req_ready |-> mem_oe_n && mem_we_n && !mem_dout_en)
		else $error("strobes active while idle");
	// A refused protected write stays idle but answers with an error at once
	chk_take_busy: assert property (req_valid && req_ready |=> !req_ready || rsp_error)
		else $error("request taken but still ready");
	chk_rsp_bound: assert property (req_valid && req_ready |-> ##[1:300] rsp_valid)
		else $error("transfer never completed");
	chk_err_access: assert property (pslverr |-> psel && penable && pready)
		else $error("slave error outside access phase");
	// Main scenarios: a read strobe, a write strobe, a completion
	cover property ($fell(mem_oe_n));
	cover property ($fell(mem_we_n));
	cover property (rsp_valid);
endmodule
bind static_bank_timing static_bank_timing_checker i_chk (.mclk, .reset, .psel, .penable,
	.pready, .pslverr, .req_valid, .req_ready, .rsp_valid, .rsp_error, .mem_cs, .mem_oe_n,
	.mem_we_n,
	.mem_blsel_n, .mem_dout_en);

//--- test_static_bank_timing.sv
// Self-checking bench for the static bank timing block.
// Assumes the register map header and the memory partner model.
`timescale 1ns/10ps
`include "static_bank_map.vh"
module test_static_bank_timing;
	reg         mclk, reset, psel, penable, pwrite, req_valid, req_write, req_seq;
	reg  [7:0]  paddr;
	reg  [31:0] pwdata, req_wdata, rd, d;
	reg  [1:0]  req_bank, req_size;
	reg  [23:0] req_addr;
	reg  [3:0]  cs_idle;
	reg         e;
	reg  [31:0] ww [0:3];
	wire        pready, pslverr, req_ready, rsp_valid, rsp_error, mem_oe_n, mem_we_n;
	wire        mem_dout_en, mem_wait;
	wire [31:0] prdata, rsp_rdata, mem_dout, mem_din, wr_word;
	wire [3:0]  mem_cs, mem_blsel_n;
	wire [23:0] mem_addr;
	time        oe_dt, we_dt, rel_dt;
	integer     fails = 0, tests_run = 0, i, n, bw;
	static_bank_timing i_dut (.mclk, .reset, .psel, .penable, .pwrite, .paddr, .pwdata,
		.pready, .prdata, .pslverr, .req_valid, .req_ready, .req_write, .req_bank, .req_addr,
		.req_size, .req_seq, .req_wdata, .rsp_valid, .rsp_rdata, .rsp_error, .mem_cs,
		.mem_oe_n, .mem_we_n, .mem_blsel_n, .mem_addr, .mem_dout, .mem_dout_en, .mem_din,
		.mem_wait);
	mem_partner i_mem (.mclk, .mem_cs, .cs_idle, .mem_oe_n, .mem_we_n, .mem_addr, .mem_dout,
		.mem_din, .mem_wait, .oe_dt, .we_dt, .rel_dt, .wr_word);
	////////////////////////////////////////////////////////////////////
	task check(input [31:0] got, input [31:0] want);
		begin
			tests_run = tests_run + 1;
			if (got !== want) begin
				fails = fails + 1;
				$display("Error t=%0t got=%h exp=%h", $time, got, want);
			end
		end
	endtask
	// APB transfer; pready is waited for, not assumed
	task apb(input w, input [7:0] a, input [31:0] wd);
		begin
			@(posedge mclk);
			psel <= 1'b1;
			pwrite <= w;
			paddr <= a;
			pwdata <= wd;
			@(posedge mclk);
			penable <= 1'b1;
			@(posedge mclk);
			while (pready !== 1'b1) @(posedge mclk);
			rd = prdata;
			e = pslverr;
			psel <= 1'b0;
			penable <= 1'b0;
		end
	endtask
	task wreg(input [1:0] b, input [2:0] f, input [31:0] wd);
		apb(1'b1, b * `BANK_STRIDE + {3'h0, f, 2'h0}, wd);
	endtask
	task rreg(input [1:0] b, input [2:0] f, input [31:0] want);
		begin
			apb(1'b0, b * `BANK_STRIDE + {3'h0, f, 2'h0}, 32'h0000_0000);
			check(rd, want);
		end
	endtask
	// One word transfer; n counts clocks from take to completion
	task xfer(input w, input [1:0] b, input [23:0] a, input [31:0] wd);
		begin
			@(posedge mclk);
			req_valid <= 1'b1;
			req_write <= w;
			req_bank <= b;
			req_addr <= a;
			req_wdata <= wd;
			@(posedge mclk);
			while (req_ready !== 1'b1) @(posedge mclk);
			req_valid <= 1'b0;
			n = 0;
			// A refused write answers at the take edge itself
			#1;
			while (rsp_valid !== 1'b1 && n < 400) begin
				@(posedge mclk);
				#1;
				n = n + 1;
			end
		end
	endtask
	// Byte k comes from the beat that carries it; all lanes hold one pattern
	function [31:0] exp_rd(input [23:0] a, input integer w);
		integer k;
		begin
			for (k = 0; k < 4; k = k + 1)
				exp_rd[8*k +: 8] = (a[7:0] + (k / w) * w) ^ 8'h5a;
		end
	endfunction
	task end_sim;
		begin
			$display("tests_run=%0d fails=%0d", tests_run, fails);
			if (fails == 0 && tests_run > 0)
				$display("bench passed");
			else
				$display("bench failed");
			$finish;
		end
	endtask
	////////////////////////////////////////////////////////////////////
	initial begin
		mclk = 1'b0;
		forever #4 mclk = ~mclk;
	end
	initial begin
		#200000;
		fails = fails + 1;
		end_sim;
	end
	initial begin
		i = $urandom(32'h93b7);
		{reset, psel, penable, pwrite, req_valid, req_write, req_seq} = 7'h40;
		{paddr, pwdata, req_wdata, req_bank, req_addr} = 98'h0;
		req_size = 2'h2;
		cs_idle = 4'hf;
		repeat (5) @(posedge mclk);
		reset <= 1'b0;
		check(mem_cs, 4'hf);
		for (i = 0; i < 4; i = i + 1) begin
			rreg(i, `FLD_WRITE_WAIT, 32'h0000_001f);
			rreg(i, `FLD_OE_DELAY, 32'h0000_0000);
			rreg(i, `FLD_WE_DELAY, 32'h0000_0001);
			rreg(i, `FLD_CONFIG, i == 0 ? 32'h80 : i == 2 ? 32'h40 : 32'h0);
			ww[i] = $urandom;
			wreg(i, `FLD_WRITE_WAIT, ww[i]);
		end
		for (i = 0; i < 4; i = i + 1)
			rreg(i, `FLD_WRITE_WAIT, ww[i] & 32'h0000_001f);
		wreg(3, `FLD_CONFIG, 32'hffff_ffff);
		rreg(3, `FLD_CONFIG, 32'h0000_00f9);
		check(mem_cs, 4'h7);
		// Bank 3 is write protected now: refused at once with an error
		xfer(1'b1, 3, 24'h000000, ww[3]);
		check({n[30:0], rsp_error}, 32'h0000_0001);
		wreg(3, `FLD_CONFIG, 32'h0000_0000);
		apb(1'b0, 8'ha0, 32'h0000_0000);
		check({31'h0, e}, 32'h0000_0001);
		check(rd, 32'h0000_0000);
		for (i = 2; i >= 0; i = i - 1) begin
			bw = i == 0 ? 4 : i;
			wreg(i, `FLD_READ_WAIT, 32'h0000_0003);
			wreg(i, `FLD_WRITE_WAIT, 32'h0000_0002);
			xfer(1'b0, i, 24'h000100, 32'h0);
			check(n, (4 / bw) * 4 - 1);
			check(rsp_rdata, exp_rd(24'h000100, bw));
			d = $urandom;
			xfer(1'b1, i, 24'h000104, d);
			check(n, (4 / bw) * 3 - 1);
		end
		check(wr_word, d);
		check(we_dt, 4);
		check(rel_dt, 4);
		wreg(1, `FLD_CONFIG, 32'h0000_0020);
		wreg(1, `FLD_WRITE_WAIT, 32'h0000_0001);
		xfer(1'b0, 1, 24'h000200, 32'h0);
		check(n, 9);
		check(rsp_rdata, exp_rd(24'h000200, 1));
		apb(1'b1, `WAITCTL_BASE, 32'h0000_0001);
		wreg(0, `FLD_OE_DELAY, 32'h0000_0002);
		wreg(0, `FLD_WE_DELAY, 32'h0000_0002);
		// Four clocks leave the delayed strobe room before the last clock
		wreg(0, `FLD_WRITE_WAIT, 32'h0000_0004);
		xfer(1'b0, 0, 24'h000300, 32'h0);
		check(oe_dt, 16);
		check(rsp_rdata, exp_rd(24'h000300, 4));
		xfer(1'b1, 0, 24'h000300, 32'h0000_a5c3);
		check(we_dt, 20);
		check(n, 4);
		end_sim;
	end
endmodule
